// ### hdl/aeqc_pkg.sv
// Contract
// [RQ1] debug bit 5 mirrors remote self-test state
// [RQ2] debug bit 1 corrupts every back-channel frame
// [RQ3] debug bit 0 corrupts one frame, self-clears
// [RQ4] step wait 164 us doubling per code
// [RQ5] first-lock mode bit restarts search at zero
// [RQ6] restart bit restarts adaption, then self-clears
// [RQ7] floor-enable bit starts adaption from floor
// [RQ8] floor value field, default 0x8
// [RQ9] status shows stage one 5:3, two 2:0
// [RQ10] bypass uses manual stage values as setting
// [RQ11] bypass bit 0 disables adaption, default enabled
// [RQ12] lock-mode bit makes lock await adaption
// [RQ13] adaption never passes upper limit, default 0xF
// [RQ14] at limit without lock, wrap to start
`default_nettype none
package aeqc_pkg;
   // ------------------------------------------------------------
   // register offsets
   // ------------------------------------------------------------
   localparam logic [7:0] PORT_DEBUG_CTL_ADDR  = 8'hd0;  // debug and error injection
   localparam logic [7:0] EQ_ADAPT_CTL_ADDR    = 8'hd2;  // adaption control
   localparam logic [7:0] EQ_ADAPT_STATUS_ADDR = 8'hd3;  // current setting
   localparam logic [7:0] EQ_BYPASS_CTL_ADDR   = 8'hd4;  // manual setting and lock mode
   localparam logic [7:0] EQ_LIMIT_CTL_ADDR    = 8'hd5;  // upper limit and floor
   // ------------------------------------------------------------
   // field positions
   // ------------------------------------------------------------
   localparam int DBG_SELFTEST_BIT   = 5;   // remote_selftest_active
   localparam int DBG_CONT_ERR_BIT   = 1;   // inject_continuous_return_errors
   localparam int DBG_ONE_ERR_BIT    = 0;   // inject_single_return_error
   localparam int ADP_WAIT_LSB       = 5;   // eq_step_wait_time, 3 bits
   localparam int ADP_FIRST_LOCK_BIT = 4;   // initial_lock_restart_sel
   localparam int ADP_RESTART_BIT    = 3;   // equalizer_adapt_restart
   localparam int ADP_FLOOR_EN_BIT   = 2;   // start_from_floor_en
   localparam int BYP_STAGE1_LSB     = 5;   // manual_stage_one_level, 3 bits
   localparam int BYP_LOCK_WAIT_BIT  = 4;   // lock_waits_for_adapt
   localparam int BYP_STAGE2_LSB     = 1;   // manual_stage_two_level, 3 bits
   localparam int BYP_MANUAL_BIT     = 0;   // manual_equalizer_sel
   localparam int LIM_UPPER_LSB      = 4;   // equalizer_upper_limit, 4 bits
   localparam int LIM_FLOOR_LSB      = 0;   // equalizer_start_floor, 4 bits
   // ------------------------------------------------------------
   // reset values
   // ------------------------------------------------------------
   localparam logic [7:0] DEBUG_RST  = 8'h00;
   localparam logic [2:0] WAIT_RST   = 3'h4;   // 2.62 ms
   localparam logic [7:0] BYPASS_RST = 8'h60;  // stage one manual 0x3
   localparam logic [3:0] UPPER_RST  = 4'hf;
   localparam logic [3:0] FLOOR_RST  = 4'h8;
   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_PERIOD_PS      = 25000;   // 40 MHz
   localparam int STEP_WAIT_BASE_PS  = 164000000; // 164 us at code 000
   localparam int STEP_WAIT_BASE_CYC =
      (STEP_WAIT_BASE_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
   localparam int TIMER_W            = 24;      // holds base << 7
   // ------------------------------------------------------------
   // engine states
   // ------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_SEARCH = 2'b00,  // stepping through settings
      ST_LOCKED = 2'b01   // receiver locked, setting held
   } aeqc_state_e;
endpackage : aeqc_pkg
`default_nettype wire

// ### hdl/aeqc_link_if.sv
`timescale 1ns/100ps
`default_nettype none
// carries control from the register bank to the engine and status back
interface aeqc_link_if;
   logic       bypass;             // manual setting selected
   logic [5:0] manual_setting;     // manual stage one and two
   logic       floor_en;           // start from floor
   logic [3:0] floor_val;          // floor index
   logic [3:0] max_val;            // upper index limit
   logic [2:0] wait_code;          // step wait code
   logic       first_lock_restart; // restart at zero on first lock
   logic       restart;            // one-cycle restart request
   logic       lock_in;            // raw lock detector
   logic [5:0] setting;            // applied setting
   logic       adapt_done;         // adaption complete
   modport ctl (output bypass, manual_setting, floor_en, floor_val, max_val, wait_code,
                output first_lock_restart, restart, lock_in,
                input  setting, adapt_done);
   modport eng (input  bypass, manual_setting, floor_en, floor_val, max_val, wait_code,
                input  first_lock_restart, restart, lock_in,
                output setting, adapt_done);
endinterface : aeqc_link_if
`default_nettype wire

// ### hdl/aeqc_engine.sv
`timescale 1ns/100ps
`default_nettype none
module aeqc_engine import aeqc_pkg::*; #(
   parameter int unsigned WAIT_BASE_CYC = STEP_WAIT_BASE_CYC
) (
   // clock and reset
   input wire logic   clock_i,
   input wire logic   rst_i,
   input wire logic   ce_i,
   // link to the register bank
   aeqc_link_if.eng   lnk
);
   // ------------------------------------------------------------
   // helpers
   // ------------------------------------------------------------
   // starting index, never above the limit
   function automatic logic [3:0] start_idx(input logic en, input logic [3:0] fl,
                                            input logic [3:0] mx);
      logic [3:0] v;
      v = en ? fl : 4'h0;
      return (v > mx) ? mx : v;
   endfunction

   aeqc_state_e          state_q;      // search state
   logic [3:0]           idx_q;        // adaption index
   logic [TIMER_W-1:0]   timer_q;      // step wait counter
   logic                 first_seen_q; // first lock already seen
   logic [5:0]           setting_q;    // applied setting
   logic [TIMER_W-1:0]   wait_lim;     // cycles per step
   logic [3:0]           start_v;      // current start index
   logic                 expire;       // step wait over

   assign wait_lim = TIMER_W'(WAIT_BASE_CYC) << lnk.wait_code; // RQ4
   assign start_v  = start_idx(lnk.floor_en, lnk.floor_val, lnk.max_val); // RQ7 RQ8
   assign expire   = (timer_q >= wait_lim - TIMER_W'(1));

   // ------------------------------------------------------------
   // search state machine
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q      <= ST_SEARCH;
         idx_q        <= 4'h0;
         timer_q      <= '0;
         first_seen_q <= 1'b0;
      end else if (ce_i) begin
         if (lnk.restart) begin
            // restart from the initial value
            idx_q   <= start_v; // RQ6
            timer_q <= '0;
            state_q <= ST_SEARCH;
         end else if (!lnk.bypass) begin // RQ11
            case (state_q)
               ST_SEARCH: begin
                  if (lnk.lock_in) begin
                     first_seen_q <= 1'b1;
                     if (!first_seen_q && lnk.first_lock_restart) begin
                        // first lock forces a fresh search at zero
                        idx_q   <= 4'h0; // RQ5
                        timer_q <= '0;
                     end else begin
                        state_q <= ST_LOCKED;
                     end
                  end else if (expire) begin
                     timer_q <= '0;
                     // step or wrap, never above the limit
                     idx_q   <= (idx_q >= lnk.max_val) ? start_v : idx_q + 4'h1; // RQ13 RQ14
                  end else begin
                     timer_q <= timer_q + TIMER_W'(1); // RQ4
                  end
               end
               ST_LOCKED: begin
                  // lock lost, resume stepping from the held value
                  if (!lnk.lock_in) begin
                     state_q <= ST_SEARCH;
                     timer_q <= '0;
                  end
               end
               default: state_q <= ST_SEARCH;
            endcase
         end
      end
   end

   // ------------------------------------------------------------
   // applied setting
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         setting_q <= 6'h00;
      end else if (ce_i) begin
         setting_q <= lnk.bypass ? lnk.manual_setting : {2'b00, idx_q}; // RQ10
      end
   end

   assign lnk.setting    = setting_q;
   assign lnk.adapt_done = lnk.bypass || (state_q == ST_LOCKED);

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_step_end;
      ce_i && !lnk.restart && !lnk.bypass && state_q == ST_SEARCH && !lnk.lock_in && expire;
   endsequence

   a_step_upper_limit: assert property ( // RQ13
      s_step_end and (idx_q < lnk.max_val) |=> idx_q == $past(idx_q) + 4'h1 && idx_q <= $past(lnk.max_val))
      else $error("index passed limit or did not step");
   a_wrap_to_start: assert property ( // RQ14
      s_step_end and (idx_q >= lnk.max_val) |=> idx_q == $past(start_v))
      else $error("index did not wrap to start");
   a_restart_floor: assert property ( // RQ7
      ce_i && lnk.restart && lnk.floor_en && lnk.floor_val <= lnk.max_val
      |=> idx_q == $past(lnk.floor_val) && timer_q == '0)
      else $error("restart did not load floor");
   a_first_lock_zero: assert property ( // RQ5
      ce_i && !lnk.restart && !lnk.bypass && state_q == ST_SEARCH && lnk.lock_in
      && !first_seen_q && lnk.first_lock_restart |=> idx_q == 4'h0 && state_q == ST_SEARCH)
      else $error("first lock did not restart at zero");
   a_bypass_setting: assert property ( // RQ10
      ce_i && lnk.bypass |=> setting_q == $past(lnk.manual_setting))
      else $error("bypass setting not applied");
endmodule : aeqc_engine
`default_nettype wire

// ### hdl/aeqc_regs.sv
`timescale 1ns/100ps
`default_nettype none
module aeqc_regs import aeqc_pkg::*; #(
   parameter int unsigned WAIT_BASE_CYC = STEP_WAIT_BASE_CYC  // cycles at wait code 000
) (
   // clock and reset
   input  wire logic       clock_i,
   input  wire logic       rst_i,
   input  wire logic       ce_i,
   // register access port
   input  wire logic [7:0] reg_addr_i,
   input  wire logic       reg_wr_i,
   input  wire logic [7:0] reg_wdata_i,
   input  wire logic       reg_rd_i,
   output logic      [7:0] reg_rdata_o,
   // link side
   input  wire logic       remote_selftest_i,
   input  wire logic       cdr_lock_i,
   input  wire logic       bc_frame_start_i,
   output logic            bc_corrupt_o,
   output logic            rx_lock_o,
   output logic      [5:0] eq_setting_o
);
   // ------------------------------------------------------------
   // storage
   // ------------------------------------------------------------
   aeqc_link_if lnk ();

   logic [7:0] dbg_q;        // debug bits, 5 and 0 unused here
   logic       one_err_q;    // single error pending
   logic [2:0] wait_q;       // step wait code
   logic [4:2] adp_q;        // first lock, unused, floor enable
   logic       restart_q;    // restart pulse
   logic [7:0] byp_q;        // bypass register
   logic [3:0] upper_q;      // upper limit
   logic [3:0] floor_q;      // floor value
   logic       corrupt_q;    // corrupt current frame
   logic       lock_q;       // reported lock
   logic [7:0] rdata_q;      // read data

   logic       wr_en;        // qualified write
   assign wr_en = ce_i && reg_wr_i;

   // ------------------------------------------------------------
   // debug register
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         dbg_q <= DEBUG_RST;
      end else if (wr_en && reg_addr_i == PORT_DEBUG_CTL_ADDR) begin
         dbg_q <= reg_wdata_i;
      end
   end

   // single error request: set wins over consumption
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         one_err_q <= 1'b0;
      end else if (ce_i) begin
         if (wr_en && reg_addr_i == PORT_DEBUG_CTL_ADDR && reg_wdata_i[DBG_ONE_ERR_BIT]) begin
            one_err_q <= 1'b1; // RQ3
         end else if (bc_frame_start_i) begin
            one_err_q <= 1'b0; // RQ3
         end
      end
   end

   // frame corruption held for a whole frame
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         corrupt_q <= 1'b0;
      end else if (ce_i && bc_frame_start_i) begin
         corrupt_q <= dbg_q[DBG_CONT_ERR_BIT] || one_err_q; // RQ2 RQ3
      end
   end

   // ------------------------------------------------------------
   // adaption control register
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wait_q <= WAIT_RST;
         adp_q  <= 3'h0;
      end else if (wr_en && reg_addr_i == EQ_ADAPT_CTL_ADDR) begin
         wait_q <= reg_wdata_i[ADP_WAIT_LSB +: 3]; // RQ4
         adp_q  <= reg_wdata_i[4:2];
      end
   end

   // restart lasts one cycle and reads back as zero
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         restart_q <= 1'b0;
      end else if (ce_i) begin
         restart_q <= reg_wr_i && reg_addr_i == EQ_ADAPT_CTL_ADDR
                      && reg_wdata_i[ADP_RESTART_BIT]; // RQ6
      end
   end

   // ------------------------------------------------------------
   // bypass and limit registers
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         byp_q   <= BYPASS_RST;
         upper_q <= UPPER_RST;
         floor_q <= FLOOR_RST;
      end else if (wr_en) begin
         if (reg_addr_i == EQ_BYPASS_CTL_ADDR) begin
            byp_q <= reg_wdata_i;
         end
         if (reg_addr_i == EQ_LIMIT_CTL_ADDR) begin
            upper_q <= reg_wdata_i[LIM_UPPER_LSB +: 4]; // RQ13
            floor_q <= reg_wdata_i[LIM_FLOOR_LSB +: 4]; // RQ8
         end
      end
   end

   // ------------------------------------------------------------
   // engine connection
   // ------------------------------------------------------------
   assign lnk.bypass             = byp_q[BYP_MANUAL_BIT]; // RQ11
   assign lnk.manual_setting     = {byp_q[BYP_STAGE1_LSB +: 3], byp_q[BYP_STAGE2_LSB +: 3]}; // RQ10
   assign lnk.floor_en           = adp_q[ADP_FLOOR_EN_BIT]; // RQ7
   assign lnk.floor_val          = floor_q;
   assign lnk.max_val            = upper_q;
   assign lnk.wait_code          = wait_q;
   assign lnk.first_lock_restart = adp_q[ADP_FIRST_LOCK_BIT]; // RQ5
   assign lnk.restart            = restart_q;
   assign lnk.lock_in            = cdr_lock_i;

   aeqc_engine #(
      .WAIT_BASE_CYC (WAIT_BASE_CYC)
   ) u_engine (
      .clock_i (clock_i),
      .rst_i   (rst_i),
      .ce_i    (ce_i),
      .lnk     (lnk.eng)
   );

   // reported lock, optionally gated by adaption
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         lock_q <= 1'b0;
      end else if (ce_i) begin
         lock_q <= cdr_lock_i && (!byp_q[BYP_LOCK_WAIT_BIT] || lnk.adapt_done); // RQ12
      end
   end

   // ------------------------------------------------------------
   // read path, one cycle after the request
   // ------------------------------------------------------------
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rdata_q <= 8'h00;
      end else if (ce_i && reg_rd_i) begin
         case (reg_addr_i)
            PORT_DEBUG_CTL_ADDR:  rdata_q <= {dbg_q[7:6], remote_selftest_i, dbg_q[4:1],
                                              one_err_q}; // RQ1
            EQ_ADAPT_CTL_ADDR:    rdata_q <= {wait_q, adp_q[4], 1'b0, adp_q[2], 2'b00};
            EQ_ADAPT_STATUS_ADDR: rdata_q <= {2'b00, lnk.setting}; // RQ9
            EQ_BYPASS_CTL_ADDR:   rdata_q <= byp_q;
            EQ_LIMIT_CTL_ADDR:    rdata_q <= {upper_q, floor_q};
            default:              rdata_q <= 8'h00;
         endcase
      end
   end

   assign reg_rdata_o  = rdata_q;
   assign bc_corrupt_o = corrupt_q;
   assign rx_lock_o    = lock_q;
   assign eq_setting_o = lnk.setting;

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (rst_i);

   sequence s_arm_single;
      wr_en && reg_addr_i == PORT_DEBUG_CTL_ADDR && reg_wdata_i[DBG_ONE_ERR_BIT];
   endsequence
   // a frame start that consumes a pending single error, with no re-arm in the same cycle
   sequence s_frame_taken;
      ce_i && bc_frame_start_i && one_err_q && !(wr_en && reg_addr_i == PORT_DEBUG_CTL_ADDR
      && reg_wdata_i[DBG_ONE_ERR_BIT]);
   endsequence

   a_selftest_read: assert property ( // RQ1
      ce_i && reg_rd_i && reg_addr_i == PORT_DEBUG_CTL_ADDR
      |=> reg_rdata_o[DBG_SELFTEST_BIT] == $past(remote_selftest_i))
      else $error("self-test bit misreported");
   a_continuous_err: assert property ( // RQ2
      ce_i && bc_frame_start_i && dbg_q[DBG_CONT_ERR_BIT] |=> bc_corrupt_o)
      else $error("frame not corrupted in continuous mode");
   a_single_arm: assert property ( // RQ3
      s_arm_single |=> one_err_q)
      else $error("single error not armed");
   a_single_err: assert property ( // RQ3
      s_frame_taken |=> bc_corrupt_o && !one_err_q)
      else $error("single error not issued or not cleared");
   a_restart_pulse: assert property ( // RQ6
      wr_en && reg_addr_i == EQ_ADAPT_CTL_ADDR && reg_wdata_i[ADP_RESTART_BIT]
      |=> restart_q ##1 (!restart_q || $past(reg_wr_i)))
      else $error("restart not a single pulse");
   a_lock_gate: assert property ( // RQ12
      ce_i && byp_q[BYP_LOCK_WAIT_BIT] && !lnk.adapt_done |=> !rx_lock_o)
      else $error("lock reported before adaption");
   a_status_read: assert property ( // RQ9
      ce_i && reg_rd_i && reg_addr_i == EQ_ADAPT_STATUS_ADDR
      |=> reg_rdata_o == {2'b00, $past(lnk.setting)})
      else $error("status fields misreported");
endmodule : aeqc_regs
`default_nettype wire

// ### verif/aeqc_host.sv
`timescale 1ns/100ps
`default_nettype none
// host on the register port, driving just after the falling edge
module aeqc_host (
   // clock
   input  wire logic       clock_i,
   // register port
   output logic      [7:0] addr_o,
   output logic            wr_o,
   output logic      [7:0] wdata_o,
   output logic            rd_o,
   input  wire logic [7:0] rdata_i
);
   // ----------------------------------------
   // idle levels
   // ----------------------------------------
   initial begin
      addr_o = 8'h00;
      wr_o = 1'b0;
      wdata_o = 8'h00;
      rd_o = 1'b0;
   end
   // one write strobe; released data shows its inverse
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_i);
      addr_o = a;
      wdata_o = d;
      wr_o = 1'b1;
      @(negedge clock_i);
      wr_o = 1'b0;
      wdata_o = ~d;
   endtask
   // one read strobe; data taken once the registered answer has settled
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clock_i);
      addr_o = a;
      rd_o = 1'b1;
      @(negedge clock_i);
      rd_o = 1'b0;
      @(negedge clock_i);
      d = rdata_i;
   endtask
endmodule // aeqc_host
`default_nettype wire

// ### verif/test_adaptive_eq_control_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_adaptive_eq_control_regs;
   logic clock_i, rst_i, ce_i, sel_i, cdr_i, fs_i;     // stimulus
   logic [7:0] addr, wdata, rdata;                     // register port
   logic wr, rd, bc_corrupt_o, rx_lock_o;              // register strobes and link outputs
   logic [5:0] eq_setting_o;                           // applied setting
   int fails, comparisons, dbg, pend, adp, byp, lim, set_m, v, dt, e, m;
   // ----------------------------------------
   // design and host
   // ----------------------------------------
   aeqc_regs #(.WAIT_BASE_CYC(4)) aeqc_regs_inst (.clock_i(clock_i), .rst_i(rst_i),
      .ce_i(ce_i), .reg_addr_i(addr), .reg_wr_i(wr), .reg_wdata_i(wdata), .reg_rd_i(rd),
      .reg_rdata_o(rdata), .remote_selftest_i(sel_i), .cdr_lock_i(cdr_i),
      .bc_frame_start_i(fs_i), .bc_corrupt_o(bc_corrupt_o), .rx_lock_o(rx_lock_o),
      .eq_setting_o(eq_setting_o));
   aeqc_host aeqc_host_inst (.clock_i(clock_i), .addr_o(addr), .wr_o(wr),
      .wdata_o(wdata), .rd_o(rd), .rdata_i(rdata));
   // 40 MHz clock
   initial begin
      clock_i = 1'b0;
      forever #12.5 clock_i = ~clock_i;
   end
   // ----------------------------------------
   // reference model and checks
   // ----------------------------------------
   function automatic int exp_rd(input int a);
      case (a)
         'hd0: return (dbg & 'hde) | (int'(sel_i) << 5) | pend;
         'hd2: return adp & 'hf4;
         'hd3: return set_m;
         'hd4: return byp;
         'hd5: return lim;
         default: return 0;
      endcase
   endfunction
   // compare a register read with the model
   task automatic chk_reg(input int a);
      logic [7:0] d;
      aeqc_host_inst.rd(a[7:0], d);
      comparisons++;
      if (d !== exp_rd(a)) begin
         fails++;
         $display("Error %0t read %h got %h exp %h", $time, a[7:0], d, exp_rd(a));
      end
   endtask
   // compare a pin value with the model
   task automatic chk_pin(input logic [7:0] got, input int x);
      comparisons++;
      if (got !== x[7:0]) begin
         fails++;
         $display("Error %0t pin got %h exp %h", $time, got, x[7:0]);
      end
   endtask
   // write through the host and into the model
   task automatic wreg(input int a, input int d);
      aeqc_host_inst.wr(a[7:0], d[7:0]);
      if (a == 'hd0) begin
         dbg = d;
         pend = d & 1;
      end
      if (a == 'hd2) adp = d;
      if (a == 'hd4) byp = d;
      if (a == 'hd5) lim = d;
   endtask
   // one back-channel frame, corruption flag checked after it starts
   task automatic frame(input int x);
      @(negedge clock_i);
      fs_i = 1'b1;
      @(negedge clock_i);
      fs_i = 1'b0;
      @(negedge clock_i);
      chk_pin({7'h00, bc_corrupt_o}, x);
      pend = 0;
   endtask
   // wait for the next change of the applied setting
   task automatic step(output int val, output int n);
      logic [5:0] last;
      last = eq_setting_o;
      n = 0;
      do begin
         @(negedge clock_i);
         n++;
      end while (eq_setting_o === last && n < 300);
      val = eq_setting_o;
   endtask
   // reset pulse and model reset values
   task automatic do_reset();
      rst_i = 1'b1;
      repeat (2) @(negedge clock_i);
      rst_i = 1'b0;
      dbg = 0; pend = 0; adp = 'h80; byp = 'h60; lim = 'hf8; set_m = 0;
   endtask
   task automatic print_verdict();
      $display("fails %0d comparisons %0d", fails, comparisons);
      if (fails == 0 && comparisons > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // watchdog
   initial begin
      #(25 * 20000);
      fails++;
      print_verdict();
   end
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      rst_i = 1'b1; ce_i = 1'b1; sel_i = 1'b0; cdr_i = 1'b0; fs_i = 1'b0;
      fails = 0; comparisons = 0;
      void'($urandom(32'h3101));
      do_reset();
      for (int a = 'hd0; a <= 'hd5; a++) chk_reg(a);
      aeqc_host_inst.wr(8'hd3, 8'hff);
      chk_reg('hd3);
      sel_i = 1'b1;
      chk_reg('hd0);
      sel_i = 1'b0;
      wreg('hd0, $urandom & 'hdc);
      chk_reg('hd0);
      wreg('hd0, 'h01);
      chk_reg('hd0);
      frame(1);
      chk_reg('hd0);
      frame(0);
      wreg('hd0, 'h02);
      frame(1);
      frame(1);
      wreg('hd0, 'h00);
      frame(0);
      // a write while the clock enable is low must be ignored
      ce_i = 1'b0;
      aeqc_host_inst.wr(8'hd5, 8'h00);
      ce_i = 1'b1;
      chk_reg('hd5);
      // floor start, limit and wrap
      wreg('hd5, 'h32);
      wreg('hd2, 'h0c);
      repeat (3) @(negedge clock_i);
      chk_pin({2'b00, eq_setting_o}, 2);
      e = 2;
      for (int i = 0; i < 4; i++) begin
         step(v, dt);
         e = (e == 3) ? 2 : e + 1;
         chk_pin(v[7:0], e);
      end
      // wait codes 0 to 3 in turn, restart from zero
      for (int c = 0; c < 4; c++) begin
         wreg('hd2, (c << 5) | 'h08);
         repeat (3) @(negedge clock_i);
         chk_pin({2'b00, eq_setting_o}, 0);
         e = 0;
         for (int i = 0; i < 5; i++) begin
            step(v, dt);
            e = (e == 3) ? 0 : e + 1;
            chk_pin(v[7:0], e);
            if (i > 0) chk_pin({7'h00, dt == (4 << c) || dt == (4 << c) + 1}, 1);
         end
         chk_reg('hd2);
      end
      // manual values in bypass
      for (int i = 0; i < 3; i++) begin
         m = $urandom;
         wreg('hd4, (m & 'hee) | 1);
         set_m = {m[7:5], m[3:1]};
         repeat (3) @(negedge clock_i);
         chk_pin({2'b00, eq_setting_o}, set_m);
         chk_reg('hd3);
         chk_reg('hd4);
      end
      // lock reporting with and without waiting for adaption
      wreg('hd4, byp | 'h10);
      cdr_i = 1'b1;
      repeat (3) @(negedge clock_i);
      chk_pin({7'h00, rx_lock_o}, 1);
      cdr_i = 1'b0;
      repeat (3) @(negedge clock_i);
      chk_pin({7'h00, rx_lock_o}, 0);
      // adaptive mode: lock is held back until the engine has settled
      wreg('hd4, 'h10);
      cdr_i = 1'b1;
      @(negedge clock_i);
      chk_pin({7'h00, rx_lock_o}, 0);
      repeat (2) @(negedge clock_i);
      chk_pin({7'h00, rx_lock_o}, 1);
      cdr_i = 1'b0;
      wreg('hd4, 'h00);
      cdr_i = 1'b1;
      repeat (3) @(negedge clock_i);
      chk_pin({7'h00, rx_lock_o}, 1);
      cdr_i = 1'b0;
      // first lock after reset restarts the search at zero
      do_reset();
      wreg('hd2, 'h10);
      step(v, dt);
      step(v, dt);
      chk_pin(v[7:0], 2);
      cdr_i = 1'b1;
      repeat (4) @(negedge clock_i);
      chk_pin({2'b00, eq_setting_o}, 0);
      repeat (20) @(negedge clock_i);
      chk_pin({2'b00, eq_setting_o}, 0);
      chk_pin({7'h00, rx_lock_o}, 1);
      print_verdict();
   end
endmodule // test_adaptive_eq_control_regs
`default_nettype wire
